// ===== design/rsd_pkg.sv
package rsd_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int SHAMT_W = 7;
  localparam int ADDR_W = 5;
  localparam int SHIFT_MAX = 16;
  localparam int ST_W = 4;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_CORE_CONFIG = 5'h00;
  localparam logic [4:0] OFS_INT_CTRL_ONE = 5'h04;
  localparam logic [4:0] OFS_INT_STATUS = 5'h08;
  localparam logic [4:0] OFS_INT_MASK = 5'h0C;
  localparam logic [4:0] OFS_LAST_RESULT = 5'h10;
  // ----------------------------------------
  // Core configuration fields and reset
  // ----------------------------------------
  localparam int CFG_FRAC_BIT = 0;
  localparam int CFG_RND_BIT = 1;
  localparam int CFG_ACCSAT_BIT = 4;
  localparam int CFG_DATA_WRITE_SATURATE_EN_BIT = 5;
  localparam int CFG_SATB_BIT = 6;
  localparam int CFG_SATA_BIT = 7;
  localparam logic [15:0] CFG_WR_MASK = 16'h00F3;
  localparam logic [15:0] CFG_RST = 16'h0020;
  // ----------------------------------------
  // Interrupt control one fields
  // ----------------------------------------
  localparam int INT1_OVA_BIT = 10;
  localparam int INT1_OVB_BIT = 9;
  localparam int INT1_COV_BIT = 8;
  localparam logic [15:0] INT1_WR_MASK = 16'h0700;
  localparam logic [15:0] INT1_RST = 16'h0000;
  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  localparam int ST_RANGE = 0;
  localparam int ST_OVA = 1;
  localparam int ST_OVB = 2;
  localparam int ST_COV = 3;
  localparam logic [3:0] ST_RST = 4'h0;
  // ----------------------------------------
  // Rounding and saturation constants
  // ----------------------------------------
  localparam logic [15:0] LSW_HALF = 16'h8000;
  localparam logic [23:0] SAT_POS_24 = 24'h007FFF;
  localparam logic [23:0] SAT_NEG_24 = 24'hFF8000;
  localparam logic [15:0] WORD_MAX = 16'h7FFF;
  localparam logic [15:0] WORD_MIN = 16'h8000;
  localparam logic [39:0] ACC31_MAX = 40'h007FFFFFFF;
  localparam logic [39:0] ACC31_MIN = 40'hFF80000000;
  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_STORE_ACC, OP_STORE_ACC_RND, OP_SHIFT_ACC,
    OP_ASR, OP_LSR, OP_SL, OP_MAC_WB
  } rsd_op_type;
endpackage : rsd_pkg

// ===== design/rsd_datapath.sv
// Function
// - The round-select bit 1 of core_config_reg picks conventional or convergent rounding.
// - Rounding gives a 24-bit guard-extended word for the saturation stage, else a truncated word is stored.
// - Conventional rounding adds zero-extended accumulator bit 15 to bits 16 to 39.
// - Convergent rounding at an exact half increments only when accumulator bit 16 is one.
// - Plain store writes a truncated and the rounded store a rounded accumulator word.
// - The multiply-accumulate write-back word is always rounded.
// - The shifter moves up to 16 bits right (arithmetic, or logical for the logical word shift) or left in one cycle.
// - A positive amount shifts right, a negative left, and zero leaves the operand alone.
// - The shifter is 40 bits wide, with 40-bit accumulator and 16-bit word results.
// - The shifter serves word shifts, accumulator stores with shift and accumulator shifts.
// - core_config_reg selects multiply type, rounding, per-accumulator and write saturation.
// - interrupt_control_one holds overflow trap enables at bits 10, 9 and 8.
// - An accumulator shift beyond 16 bits always raises the arithmetic trap.
// - Such a faulting shift completes but does not write the target accumulator; an adder load in that cycle still lands.
// - Write saturation clamps above 0x007FFF to 0x7FFF and below 0xFF8000 to 0x8000.
// - A saturated store scales, then rounds, then saturates, leaving the accumulator as is.
`timescale 1ns/1ps
module rsd_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // Instruction request
  input wire logic op_valid,
  input wire rsd_pkg::rsd_op_type op_code,
  input wire logic op_acc_sel,
  input wire logic [6:0] op_shift,
  input wire logic [15:0] op_operand,
  // Accumulator load from the DSP adder
  input wire logic acc_load,
  input wire logic acc_load_sel,
  input wire logic [39:0] acc_load_data,
  input wire logic cat_ovf_a,
  input wire logic cat_ovf_b,
  // Results
  output logic [15:0] res_word,
  output logic res_word_valid,
  output logic [39:0] acc_a_out,
  output logic [39:0] acc_b_out,
  output logic [15:0] wb_word,
  output logic wb_valid,
  output logic cfg_frac_mult,
  output logic arith_trap,
  output logic irq
);
  // ----------------------------------------
  // Datapath functions
  // ----------------------------------------
  // Signed barrel shift, magnitude capped at the hardware limit
  function automatic logic [39:0] shift40(input logic [39:0] v, input logic [6:0] amt,
                                          input logic arith);
    logic [6:0] mag;
    logic [39:0] r;
    mag = amt[6] ? 7'(~amt + 7'h01) : amt;
    if (mag > 7'(rsd_pkg::SHIFT_MAX)) begin
      mag = 7'(rsd_pkg::SHIFT_MAX);
    end
    if (amt[6]) begin
      r = v << mag;
    end else if (arith) begin
      r = 40'($signed(v) >>> mag);
    end else begin
      r = v >> mag;
    end
    return r;
  endfunction : shift40

  // Round the upper 24 bits; guard bits kept for saturation
  function automatic logic [23:0] round24(input logic [39:0] a, input logic conv);
    logic inc;
    inc = a[15];
    if (conv && a[15:0] == rsd_pkg::LSW_HALF && !a[16]) begin
      inc = 1'b0;
    end
    return a[39:16] + {23'h000000, inc};
  endfunction : round24

  // Clamp to a 1.15 word when write saturation is on
  function automatic logic [15:0] sat16(input logic [23:0] v, input logic en);
    logic [15:0] r;
    r = v[15:0];
    if (en && $signed(v) > $signed(rsd_pkg::SAT_POS_24)) begin
      r = rsd_pkg::WORD_MAX;
    end else if (en && $signed(v) < $signed(rsd_pkg::SAT_NEG_24)) begin
      r = rsd_pkg::WORD_MIN;
    end
    return r;
  endfunction : sat16

  // Accumulator saturation; only 31-bit mode can catch a shift overflow
  function automatic logic [39:0] sat_acc(input logic [39:0] v, input logic en,
                                          input logic mode39);
    logic [39:0] r;
    r = v;
    if (en && !mode39 && !(&v[39:31] || ~|v[39:31])) begin
      r = v[39] ? rsd_pkg::ACC31_MIN : rsd_pkg::ACC31_MAX;
    end
    return r;
  endfunction : sat_acc

  // Guard bits hold more than sign extension
  function automatic logic guard_ovf(input logic [39:0] v);
    return !(&v[39:31] || ~|v[39:31]);
  endfunction : guard_ovf

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] cfg_q, cfg_d;
  logic [15:0] int1_q, int1_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] mask_q, mask_d;
  logic [39:0] acc_q [2];
  logic [39:0] acc_d [2];
  logic [15:0] res_q, res_d;
  logic res_v_q, res_v_d;
  logic [15:0] wb_q, wb_d;
  logic wb_v_q, wb_v_d;
  logic trap_q, trap_d;
  logic [15:0] rdata_q, rdata_d;
  logic [39:0] tgt;
  logic [39:0] scaled;
  logic [39:0] word_in;
  logic [3:0] ev;
  logic range_bad;
  logic conv;
  logic data_write_saturate_en;
  logic [15:0] tgt_hi, tgt_hi_inc, oth_hi_inc;
  logic opnd_sign;

  // Target accumulator and shared shifter input
  assign tgt = acc_q[op_acc_sel];
  assign conv = cfg_q[rsd_pkg::CFG_RND_BIT];
  assign data_write_saturate_en = cfg_q[rsd_pkg::CFG_DATA_WRITE_SATURATE_EN_BIT];
  assign range_bad = $signed(op_shift) > $signed(7'(rsd_pkg::SHIFT_MAX)) ||
                     $signed(op_shift) < -$signed(7'(rsd_pkg::SHIFT_MAX));

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    int1_d = int1_q;
    mask_d = mask_q;
    acc_d = acc_q;
    res_d = res_q;
    res_v_d = 1'b0;
    wb_d = wb_q;
    wb_v_d = 1'b0;
    ev = '0;
    rdata_d = '0;
    word_in = '0;
    scaled = '0;
    // Load from the adder; an in-range shift to the same accumulator overrides below
    if (acc_load) begin
      acc_d[acc_load_sel] = acc_load_data;
      ev[rsd_pkg::ST_OVA] = !acc_load_sel && guard_ovf(acc_load_data)
                            && int1_q[rsd_pkg::INT1_OVA_BIT];
      ev[rsd_pkg::ST_OVB] = acc_load_sel && guard_ovf(acc_load_data)
                            && int1_q[rsd_pkg::INT1_OVB_BIT];
    end
    // Catastrophic overflow only traps while that accumulator is unsaturated
    ev[rsd_pkg::ST_COV] = int1_q[rsd_pkg::INT1_COV_BIT] &&
      ((cat_ovf_a && !cfg_q[rsd_pkg::CFG_SATA_BIT]) ||
       (cat_ovf_b && !cfg_q[rsd_pkg::CFG_SATB_BIT]));
    if (op_valid) begin
      case (op_code)
        rsd_pkg::OP_STORE_ACC: begin
          scaled = shift40(tgt, op_shift, 1'b1);
          res_d = sat16(scaled[39:16], data_write_saturate_en);
          res_v_d = 1'b1;
        end
        rsd_pkg::OP_STORE_ACC_RND: begin
          scaled = shift40(tgt, op_shift, 1'b1);
          res_d = sat16(round24(scaled, conv), data_write_saturate_en);
          res_v_d = 1'b1;
        end
        rsd_pkg::OP_SHIFT_ACC: begin
          scaled = shift40(tgt, op_shift, 1'b1);
          ev[rsd_pkg::ST_RANGE] = range_bad;
          if (!range_bad) begin
            acc_d[op_acc_sel] = sat_acc(scaled,
              op_acc_sel ? cfg_q[rsd_pkg::CFG_SATB_BIT] : cfg_q[rsd_pkg::CFG_SATA_BIT],
              cfg_q[rsd_pkg::CFG_ACCSAT_BIT]);
          end
        end
        rsd_pkg::OP_ASR, rsd_pkg::OP_LSR, rsd_pkg::OP_SL: begin
          // Word operand sits low; sign fill only for the arithmetic form
          word_in = (op_code == rsd_pkg::OP_ASR) ?
                    {{24{op_operand[15]}}, op_operand} : {24'h000000, op_operand};
          scaled = shift40(word_in, op_code == rsd_pkg::OP_SL ?
                           7'(~op_shift + 7'h01) : op_shift,
                           op_code == rsd_pkg::OP_ASR);
          res_d = scaled[15:0];
          res_v_d = 1'b1;
        end
        rsd_pkg::OP_MAC_WB: begin
          // Other accumulator, rounded whatever the instruction asks
          wb_d = sat16(round24(acc_q[!op_acc_sel], conv), data_write_saturate_en);
          wb_v_d = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Register writes
    if (reg_we) begin
      if (reg_addr == rsd_pkg::OFS_CORE_CONFIG) begin
        cfg_d = reg_wdata & rsd_pkg::CFG_WR_MASK;
      end else if (reg_addr == rsd_pkg::OFS_INT_CTRL_ONE) begin
        int1_d = reg_wdata & rsd_pkg::INT1_WR_MASK;
      end else if (reg_addr == rsd_pkg::OFS_INT_MASK) begin
        mask_d = reg_wdata[3:0];
      end
    end
    // Register reads; unmapped offsets read zero
    if (reg_re) begin
      if (reg_addr == rsd_pkg::OFS_CORE_CONFIG) begin
        rdata_d = cfg_q;
      end else if (reg_addr == rsd_pkg::OFS_INT_CTRL_ONE) begin
        rdata_d = int1_q;
      end else if (reg_addr == rsd_pkg::OFS_INT_STATUS) begin
        rdata_d = {12'h000, stat_q};
      end else if (reg_addr == rsd_pkg::OFS_INT_MASK) begin
        rdata_d = {12'h000, mask_q};
      end else if (reg_addr == rsd_pkg::OFS_LAST_RESULT) begin
        rdata_d = res_q;
      end
    end
    // Read clears, but a new event in the same cycle survives
    stat_d = ((reg_re && reg_addr == rsd_pkg::OFS_INT_STATUS) ? 4'h0 : stat_q) | ev;
    trap_d = |ev;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= rsd_pkg::CFG_RST;
      int1_q <= rsd_pkg::INT1_RST;
      stat_q <= rsd_pkg::ST_RST;
      mask_q <= 4'h0;
      acc_q[0] <= 40'h0000000000;
      acc_q[1] <= 40'h0000000000;
      res_q <= 16'h0000;
      res_v_q <= 1'b0;
      wb_q <= 16'h0000;
      wb_v_q <= 1'b0;
      trap_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q <= cfg_d;
      int1_q <= int1_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      acc_q <= acc_d;
      res_q <= res_d;
      res_v_q <= res_v_d;
      wb_q <= wb_d;
      wb_v_q <= wb_v_d;
      trap_q <= trap_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign res_word = res_q;
  assign res_word_valid = res_v_q;
  assign wb_word = wb_q;
  assign wb_valid = wb_v_q;
  assign acc_a_out = acc_q[0];
  assign acc_b_out = acc_q[1];
  assign cfg_frac_mult = cfg_q[rsd_pkg::CFG_FRAC_BIT];
  assign arith_trap = trap_q;
  assign irq = |(stat_q & mask_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Whole-signal views, so that each $past sees a plain signal
  assign tgt_hi = tgt[31:16];
  assign tgt_hi_inc = tgt[31:16] + {15'h0000, tgt[15]};
  assign oth_hi_inc = acc_q[!op_acc_sel][31:16] + {15'h0000, acc_q[!op_acc_sel][15]};
  assign opnd_sign = op_operand[15];
  round_conv_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_STORE_ACC_RND && op_shift == 7'h00 && !conv
    && !data_write_saturate_en |=> res_word == $past(tgt_hi_inc))
    else $error("conventional round wrong");
  round_even_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_STORE_ACC_RND && op_shift == 7'h00 && conv
    && tgt[15:0] == rsd_pkg::LSW_HALF && !tgt[16] && !data_write_saturate_en
    |=> res_word == $past(tgt_hi))
    else $error("convergent half not held");
  store_trunc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_STORE_ACC && op_shift == 7'h00 && !data_write_saturate_en
    |=> res_word_valid && res_word == $past(tgt_hi))
    else $error("truncated store wrong");
  sat_pos_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_STORE_ACC && op_shift == 7'h00 && data_write_saturate_en
    && !tgt[39] && tgt[39:31] != 9'h000 |=> res_word == rsd_pkg::WORD_MAX)
    else $error("positive clamp missing");
  wb_round_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_MAC_WB && !conv && !data_write_saturate_en
    |=> wb_valid && wb_word == $past(oth_hi_inc))
    else $error("write-back not rounded");
  range_trap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_SHIFT_ACC && range_bad
    |=> arith_trap && stat_q[rsd_pkg::ST_RANGE])
    else $error("range trap not raised");
  range_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_SHIFT_ACC && range_bad && !acc_load && !op_acc_sel
    |=> $stable(acc_a_out))
    else $error("faulting shift changed accumulator");
  asr_sign_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_ASR && op_shift == 7'h10
    |=> res_word == {16{$past(opnd_sign)}})
    else $error("arithmetic shift fill wrong");
  zero_shift_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    op_valid && op_code == rsd_pkg::OP_LSR && op_shift == 7'h00
    |=> res_word == $past(op_operand))
    else $error("zero shift changed operand");
  ova_trap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    acc_load && !acc_load_sel && guard_ovf(acc_load_data) && int1_q[rsd_pkg::INT1_OVA_BIT]
    |=> arith_trap ##1 stat_q[rsd_pkg::ST_OVA] || $past(reg_re))
    else $error("overflow trap missing");
endmodule : rsd_datapath

// ===== dv/rsd_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Instruction decoder and adder stand-in
// ----------------------------------------
module rsd_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Instruction request
  output logic op_valid,
  output rsd_pkg::rsd_op_type op_code,
  output logic op_acc_sel,
  output logic [6:0] op_shift,
  output logic [15:0] op_operand,
  // Adder writes and overflow pulses
  output logic acc_load,
  output logic acc_load_sel,
  output logic [39:0] acc_load_data,
  output logic cat_ovf_a,
  output logic cat_ovf_b
);
  // Idle levels from time zero
  initial begin
    op_valid = 1'b0;
    op_code = rsd_pkg::OP_NONE;
    op_acc_sel = 1'b0;
    op_shift = 7'h00;
    op_operand = 16'h0000;
    acc_load = 1'b0;
    acc_load_sel = 1'b0;
    acc_load_data = 40'h0000000000;
    cat_ovf_a = 1'b0;
    cat_ovf_b = 1'b0;
  end
  // One instruction, taken at the second edge; shift and operand flip on release so stale data never helps
  task automatic issue(input rsd_pkg::rsd_op_type c, input logic s, input logic [6:0] sh,
      input logic [15:0] d);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_acc_sel <= s;
    op_shift <= sh;
    op_operand <= d;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    op_shift <= ~sh;
    op_operand <= ~d;
  endtask : issue
  // Adder result written into one accumulator
  task automatic load(input logic s, input logic [39:0] d);
    @(posedge clk_sys);
    acc_load <= 1'b1;
    acc_load_sel <= s;
    acc_load_data <= d;
    @(posedge clk_sys);
    acc_load <= 1'b0;
    acc_load_data <= ~d;
  endtask : load
  // Catastrophic overflow pulse from the adder
  task automatic cat(input logic s);
    @(posedge clk_sys);
    cat_ovf_a <= !s;
    cat_ovf_b <= s;
    @(posedge clk_sys);
    cat_ovf_a <= 1'b0;
    cat_ovf_b <= 1'b0;
  endtask : cat
endmodule : rsd_cpu_model

// ===== dv/rsd_datapath_tb_top.sv
`timescale 1ns/1ps
module rsd_datapath_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys, sys_rst, reg_we, reg_re, op_valid, op_acc_sel, acc_load, acc_load_sel;
  logic cat_ovf_a, cat_ovf_b, res_word_valid, wb_valid, cfg_frac_mult, arith_trap, irq;
  logic [4:0] reg_addr;
  logic [6:0] op_shift;
  logic [15:0] reg_wdata, reg_rdata, op_operand, res_word, wb_word, rd, d;
  logic [39:0] acc_load_data, acc_a_out, acc_b_out, acc;
  logic [15:0] cfgs [4] = '{16'h0020, 16'h0022, 16'h0001, 16'h0003};
  rsd_pkg::rsd_op_type op_code;
  int failures, n_checks, sh;
  rsd_cpu_model u_cpu (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
    .op_acc_sel(op_acc_sel), .op_shift(op_shift), .op_operand(op_operand), .acc_load(acc_load),
    .acc_load_sel(acc_load_sel), .acc_load_data(acc_load_data), .cat_ovf_a(cat_ovf_a),
    .cat_ovf_b(cat_ovf_b));
  rsd_datapath u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_code(op_code), .op_acc_sel(op_acc_sel), .op_shift(op_shift),
    .op_operand(op_operand), .acc_load(acc_load), .acc_load_sel(acc_load_sel),
    .acc_load_data(acc_load_data), .cat_ovf_a(cat_ovf_a), .cat_ovf_b(cat_ovf_b),
    .res_word(res_word), .res_word_valid(res_word_valid), .acc_a_out(acc_a_out),
    .acc_b_out(acc_b_out), .wb_word(wb_word), .wb_valid(wb_valid),
    .cfg_frac_mult(cfg_frac_mult), .arith_trap(arith_trap), .irq(irq));
  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  // Signed shift, magnitude capped at the shifter's reach
  function automatic logic [39:0] sh40(input logic [39:0] a, input int s);
    int m;
    m = (s < 0) ? -s : s;
    if (m > 16) m = 16;
    if (s < 0) return a << m;
    return $signed(a) >>> m;
  endfunction : sh40
  // Scale, optional round, then clamp on the guard-extended upper word
  function automatic logic [15:0] exp_store(input logic [39:0] a, input int s, input logic r,
      input logic [15:0] c);
    logic [39:0] x;
    logic [23:0] v;
    x = sh40(a, s);
    v = x[39:16] + 24'(r & ((c[1] && x[15:0] == 16'h8000) ? x[16] : x[15]));
    if (c[5] && $signed(v) > $signed(rsd_pkg::SAT_POS_24)) return rsd_pkg::WORD_MAX;
    if (c[5] && $signed(v) < $signed(rsd_pkg::SAT_NEG_24)) return rsd_pkg::WORD_MIN;
    return v[15:0];
  endfunction : exp_store
  // Word shifts: 0 arithmetic right, 1 logical right, 2 left
  function automatic logic [15:0] exp_word(input int o, input logic [15:0] x, input int s);
    int m;
    m = (s > 16) ? 16 : s;
    if (o == 0) return $signed(x) >>> m;
    if (o == 1) return x >> m;
    return x << m;
  endfunction : exp_word
  // ----------------------------------------
  // Bus tasks and reporting
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rdr
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard, bounded in cycles
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    $display("BAD %0t run did not finish", $time);
    test_done();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_we, reg_re, reg_addr, reg_wdata, failures, n_checks} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    void'($urandom(32'hC887F68D));
    rdr(rsd_pkg::OFS_CORE_CONFIG, rd); chk(rd, rsd_pkg::CFG_RST);
    rdr(rsd_pkg::OFS_INT_CTRL_ONE, rd); chk(rd, rsd_pkg::INT1_RST);
    wr(rsd_pkg::OFS_CORE_CONFIG, 16'hFFFF);
    rdr(rsd_pkg::OFS_CORE_CONFIG, rd); chk(rd, rsd_pkg::CFG_WR_MASK);
    wr(rsd_pkg::OFS_INT_CTRL_ONE, 16'hFFFF);
    rdr(rsd_pkg::OFS_INT_CTRL_ONE, rd); chk(rd, rsd_pkg::INT1_WR_MASK);
    wr(rsd_pkg::OFS_INT_CTRL_ONE, 16'h0000);
    wr(5'h14, 16'hFFFF);
    rdr(5'h14, rd); chk(rd, 16'h0000);
    $display("test registers done");
    // Stores and write-back under each rounding and saturation setting
    foreach (cfgs[k]) begin
      wr(rsd_pkg::OFS_CORE_CONFIG, cfgs[k]); chk(cfg_frac_mult, cfgs[k][0]);
      for (int i = 0; i < 40; i++) begin
        acc = {8'($urandom), 32'($urandom)};
        if (i % 3 == 0) acc[39:32] = {8{acc[31]}};
        if (i < 2) acc[16:0] = {i[0], 16'h8000};
        sh = (i < 2) ? 0 : int'($urandom_range(40)) - 20;
        u_cpu.load(1'b0, acc);
        u_cpu.load(1'b1, acc);
        u_cpu.issue(rsd_pkg::OP_STORE_ACC, 1'b0, 7'(sh), 16'h0000);
        #1;
        chk(res_word_valid, 1'b1);
        chk(res_word, exp_store(acc, sh, 1'b0, cfgs[k]));
        u_cpu.issue(rsd_pkg::OP_STORE_ACC_RND, 1'b0, 7'(sh), 16'h0000);
        #1;
        chk(res_word, exp_store(acc, sh, 1'b1, cfgs[k]));
        chk(acc_a_out, acc);
        u_cpu.issue(rsd_pkg::OP_MAC_WB, 1'b0, 7'h00, 16'h0000);
        #1;
        chk(wb_valid, 1'b1);
        chk(wb_word, exp_store(acc, 0, 1'b1, cfgs[k]));
      end
    end
    $display("test stores done");
    // Word shifts with edge counts 0, 16 and 17
    for (int i = 0; i < 30; i++) begin
      sh = (i == 0) ? 0 : (i < 3) ? 15 + i : int'($urandom_range(20));
      d = 16'($urandom);
      if (i % 2 == 1) d[15] = 1'b1;
      for (int o = 0; o < 3; o++) begin
        u_cpu.issue(rsd_pkg::rsd_op_type'(4 + o), 1'b0, 7'(sh), d);
        #1;
        chk(res_word, exp_word(o, d, sh));
      end
    end
    $display("test word shifts done");
    // Accumulator shifts in range, both limits included
    wr(rsd_pkg::OFS_CORE_CONFIG, 16'h0020);
    for (int i = 0; i < 20; i++) begin
      // Second half with B auto-saturation in 31-bit mode
      if (i == 10) wr(rsd_pkg::OFS_CORE_CONFIG, 16'h0060);
      acc = {8'($urandom), 32'($urandom)};
      sh = (i == 0) ? 16 : (i == 1) ? -16 : int'($urandom_range(32)) - 16;
      u_cpu.load(1'b1, acc);
      u_cpu.issue(rsd_pkg::OP_SHIFT_ACC, 1'b1, 7'(sh), 16'h0000);
      #1;
      acc = sh40(acc, sh);
      // Saturation clamps only a result that spills past bit 31
      if (i >= 10 && acc[39:31] != {9{acc[39]}}) acc = acc[39] ? rsd_pkg::ACC31_MIN :
          rsd_pkg::ACC31_MAX;
      chk(acc_b_out, acc);
      chk(arith_trap, 1'b0);
    end
    // Out of range: trap always, accumulator kept, irq only when unmasked
    for (int i = 0; i < 2; i++) begin
      wr(rsd_pkg::OFS_INT_MASK, (i == 0) ? 16'h0001 : 16'h0000);
      acc = {8'($urandom), 32'($urandom)};
      u_cpu.load(1'b0, acc);
      u_cpu.issue(rsd_pkg::OP_SHIFT_ACC, 1'b0, (i == 0) ? 7'h11 : 7'h6F, 16'h0000);
      #1;
      chk(arith_trap, 1'b1);
      chk(acc_a_out, acc);
      chk(irq, (i == 0));
      rdr(rsd_pkg::OFS_INT_STATUS, rd); chk(rd, 16'h0001);
      chk(irq, 1'b0);
    end
    $display("test accumulator shifts done");
    // Overflow trap enables one at a time; B saturation still on hides its catastrophe
    for (int i = 0; i < 5; i++) begin
      wr(rsd_pkg::OFS_INT_CTRL_ONE, (i < 3) ? 16'h0400 >> i : (i == 3) ? 16'h0100 : 16'h0000);
      if (i == 2 || i == 3) u_cpu.cat(i == 3);
      else u_cpu.load(i[0], 40'h0100000000);
      rdr(rsd_pkg::OFS_INT_STATUS, rd); chk(rd, (i < 3) ? 16'h0002 << i : 16'h0000);
    end
    $display("test trap enables done");
    test_done();
  end
endmodule : rsd_datapath_tb_top
